/* include/psc_regs.svh */
// Purpose: Constants for the port statistics counter block.
// Assumes: Included once through the guard below.
// Notes: Field tables are indexed by the wrap flag number.
`ifndef PSC_REGS_SVH
`define PSC_REGS_SVH
`define PSC_NUM_PORTS 10
`define PSC_NUM_WORDS 16
`define PSC_NUM_WRAP 30
`define PSC_NUM_HITS 33
`define PSC_HIT_GOOD 30
`define PSC_HIT_VLONG 31
`define PSC_HIT_MISMATCH 32
`define PSC_MIN_FRAME 14'h0040
`define PSC_MAX_UNTAGGED 14'h05EE
`define PSC_MAX_TAGGED 14'h05F2
`define PSC_SHORT_EVENT 14'h000A
`define PSC_BIN_127 14'h007F
`define PSC_BIN_255 14'h00FF
`define PSC_BIN_511 14'h01FF
`define PSC_BIN_1023 14'h03FF
`define PSC_LATE_COL_THRESHOLD 14'h0040
`define PSC_COL_LIMIT 5'h10
`define PSC_ADDR_GOOD_OCTET 5'h10
`define PSC_ADDR_GOOD_FRAME 5'h11
`define PSC_ADDR_VLONG 5'h12
`define PSC_ADDR_ERR_TOTAL 5'h13
`define PSC_WRAP_PORT_LSB 30
`define PSC_RESET_COUNT 32'h0
`define PSC_FWORD '{4'h0, 4'h1, 4'h1, 4'h2, 4'h2, 4'h3, 4'h4, 4'h5, \
  4'h6, 4'h6, 4'h7, 4'h7, 4'h8, 4'h8, 4'h9, 4'h9, 4'hA, 4'hA, 4'hB, \
  4'hB, 4'hC, 4'hC, 4'hC, 4'hD, 4'hD, 4'hE, 4'hE, 4'hF, 4'hF, 4'hF}
`define PSC_FLSB '{5'h00, 5'h00, 5'h18, 5'h00, 5'h10, 5'h00, 5'h00, \
  5'h00, 5'h00, 5'h18, 5'h00, 5'h10, 5'h00, 5'h18, 5'h00, 5'h18, \
  5'h00, 5'h10, 5'h00, 5'h10, 5'h00, 5'h10, 5'h18, 5'h00, 5'h10, \
  5'h00, 5'h10, 5'h00, 5'h10, 5'h18}
`define PSC_FWIDTH '{6'h20, 6'h18, 6'h08, 6'h10, 6'h10, 6'h20, 6'h20, \
  6'h20, 6'h18, 6'h08, 6'h10, 6'h10, 6'h18, 6'h08, 6'h18, 6'h08, \
  6'h10, 6'h10, 6'h10, 6'h10, 6'h10, 6'h08, 6'h08, 6'h10, 6'h10, \
  6'h10, 6'h10, 6'h10, 6'h08, 6'h08}
`endif

/* include/psc_pkg.sv */
// Purpose: Types and field decoding for the statistics block.
// Assumes: psc_regs.svh is on the include path.
// Notes: Field decode is used by the counter bank only.
`include "psc_regs.svh"
package psc_pkg;
  typedef logic [3:0] psc_port_t;
  typedef logic [13:0] psc_len_t;
  typedef logic [31:0] psc_word_t;
  typedef logic [`PSC_NUM_WRAP-1:0] psc_wrap_t;
  typedef logic [`PSC_NUM_HITS-1:0] psc_hit_t;
  typedef enum {PSC_SRC_RX, PSC_SRC_TX, PSC_SRC_COL, PSC_SRC_BM,
    PSC_SRC_QM} psc_src_e;
  localparam logic [3:0] PSC_FWORD [0:29] = `PSC_FWORD;
  localparam logic [4:0] PSC_FLSB [0:29] = `PSC_FLSB;
  localparam logic [5:0] PSC_FWIDTH [0:29] = `PSC_FWIDTH;

  function automatic psc_src_e psc_field_src(input int f);
    psc_src_e s;
    s = PSC_SRC_RX;
    if (f <= 4)
      s = PSC_SRC_TX;
    else if (f == 25 || f == 29)
      s = PSC_SRC_COL;
    else if (f == 27)
      s = PSC_SRC_QM;
    else if (f == 28)
      s = PSC_SRC_BM;
    return s;
  endfunction

  function automatic logic [31:0] psc_field_mask(input int f);
    logic [32:0] m;
    m = (33'h1 << PSC_FWIDTH[f]) - 33'h1;
    return m[31:0];
  endfunction
endpackage

/* include/psc_ev_if.sv */
// Purpose: Carries qualified events, wraps and reads between modules.
// Assumes: One clock domain.
// Notes: Hits are registered one cycle after the source events.
`timescale 1ns/10ps
`include "psc_regs.svh"
interface psc_ev_if;
  import psc_pkg::*;
  psc_hit_t hit;
  psc_port_t rx_port;
  psc_port_t tx_port;
  psc_port_t col_port;
  psc_port_t bm_port;
  psc_port_t qm_port;
  psc_len_t rx_len;
  psc_len_t tx_len;
  logic [`PSC_NUM_PORTS-1:0][`PSC_NUM_WRAP-1:0] wrap;
  psc_port_t rd_port;
  logic [3:0] rd_word;
  psc_word_t rd_data;
  modport src (output hit, rx_port, tx_port, col_port, bm_port, qm_port,
    rx_len, tx_len, rd_port, rd_word, input wrap, rd_data);
  modport bank (input hit, rx_port, tx_port, col_port, bm_port, qm_port,
    rx_len, tx_len, rd_port, rd_word, output wrap, rd_data);
  modport rpt (input wrap);
endinterface

/* verilog/psc_counter_bank.sv */
// Purpose: Per-port counter memory with packed rollover fields.
// Assumes: Hits arrive registered, one update per field per cycle.
// Notes: Fields sharing a word are merged in one pass.
`timescale 1ns/10ps
`include "psc_regs.svh"
module psc_counter_bank
(
  input wire logic i_ref_clk,
  input wire logic i_reset,
  input wire logic i_clk_en,
  psc_ev_if.bank ev
);
  import psc_pkg::*;
  typedef struct packed {
    logic [`PSC_NUM_PORTS-1:0][`PSC_NUM_WORDS-1:0][31:0] mem;
  } psc_bank_s;
  psc_bank_s q;
  psc_bank_s d;

  always_comb
  begin
    psc_port_t p;
    psc_word_t cur;
    psc_word_t msk;
    logic [32:0] sum;
    logic [13:0] amt;
    p = '0;
    cur = '0;
    msk = '0;
    sum = '0;
    amt = '0;
    d = q;
    ev.wrap = '0;
    for (int f = 0; f < `PSC_NUM_WRAP; f++)
    begin
      case (psc_field_src(f))
        PSC_SRC_TX: p = ev.tx_port;
        PSC_SRC_COL: p = ev.col_port;
        PSC_SRC_BM: p = ev.bm_port;
        PSC_SRC_QM: p = ev.qm_port;
        default: p = ev.rx_port;
      endcase
      amt = (f == 0) ? ev.tx_len : ((f == 5 || f == 7) ? ev.rx_len : 14'h1);
      if (ev.hit[f] && p < `PSC_NUM_PORTS)
      begin
        // Each qualifying field updates, several per word if needed.
        msk = psc_field_mask(f);
        cur = d.mem[p][PSC_FWORD[f]];
        sum = {1'b0, (cur >> PSC_FLSB[f]) & msk} + {19'h0, amt};
        // Carry out of the field is the rollover.
        if (sum > {1'b0, msk})
          ev.wrap[p][f] = 1'b1;
        d.mem[p][PSC_FWORD[f]] = (cur & ~(msk << PSC_FLSB[f]))
          | ((sum[31:0] & msk) << PSC_FLSB[f]);
      end
    end
  end

  // Reads see stored values; an update in the same cycle shows next read.
  assign ev.rd_data = (ev.rd_port < `PSC_NUM_PORTS) ?
    q.mem[ev.rd_port][ev.rd_word] : `PSC_RESET_COUNT;

  always_ff @(posedge i_ref_clk or posedge i_reset)
  begin
    if (i_reset)
      q <= '0;
    else if (i_clk_en)
      q <= d;
  end
endmodule

/* verilog/psc_wrap_report.sv */
// Purpose: Holds wrap flags per port and reports one port per cycle.
// Assumes: Reports are accepted as soon as they are issued.
// Notes: Rotating scan keeps a busy port from starving others.
`timescale 1ns/10ps
`include "psc_regs.svh"
module psc_wrap_report
(
  input wire logic i_ref_clk,
  input wire logic i_reset,
  input wire logic i_clk_en,
  psc_ev_if.rpt ev,
  output logic o_wrap_valid,
  output logic [63:0] o_wrap_word
);
  import psc_pkg::*;
  typedef struct packed {
    logic [`PSC_NUM_PORTS-1:0][`PSC_NUM_WRAP-1:0] pend;
    psc_port_t ptr;
    logic valid;
    logic [63:0] word;
  } psc_rpt_s;
  psc_rpt_s q;
  psc_rpt_s d;

  always_comb
  begin
    logic found;
    logic [4:0] idx;
    found = 1'b0;
    idx = '0;
    d = q;
    d.valid = 1'b0;
    for (int i = 0; i < `PSC_NUM_PORTS; i++)
    begin
      idx = 5'(q.ptr) + 5'(i);
      if (idx >= `PSC_NUM_PORTS)
        idx = idx - 5'(`PSC_NUM_PORTS);
      if (!found && |q.pend[idx])
      begin
        found = 1'b1;
        d.valid = 1'b1;
        d.word = '0;
        d.word[`PSC_NUM_WRAP-1:0] = q.pend[idx];
        d.word[`PSC_WRAP_PORT_LSB +: 4] = idx[3:0];
        d.pend[idx] = '0;
        d.ptr = (idx == 5'(`PSC_NUM_PORTS - 1)) ? 4'h0 : 4'(idx + 5'h1);
      end
    end
    // A rollover in the reporting cycle survives the clear.
    d.pend = d.pend | ev.wrap;
  end

  assign o_wrap_valid = q.valid;
  assign o_wrap_word = q.word;

  always_ff @(posedge i_ref_clk or posedge i_reset)
  begin
    if (i_reset)
      q <= '0;
    else if (i_clk_en)
      q <= d;
  end
endmodule

/* verilog/psc_stats_top.sv */
// Purpose: Per-port Ethernet statistics: qualify events, count, report.
// Assumes: All event and config inputs come from logic on i_ref_clk.
// Notes: Event strobes are one-cycle pulses, one per source per cycle.
`timescale 1ns/10ps
`include "psc_regs.svh"
module psc_stats_top
(
  input wire logic i_ref_clk,
  input wire logic i_reset,
  input wire logic i_clk_en,
  input wire logic i_rx_valid,
  input wire psc_pkg::psc_port_t i_rx_port,
  input wire psc_pkg::psc_len_t i_rx_len,
  input wire logic i_rx_tagged,
  input wire logic i_rx_fcs_err,
  input wire logic i_rx_frame_err,
  input wire logic i_rx_misaligned,
  input wire logic i_rx_collision,
  input wire logic i_rx_pause,
  input wire logic i_rx_mcast,
  input wire logic i_rx_bcast,
  input wire logic i_rx_drop,
  input wire logic i_rx_jabber_lockup_timer,
  input wire logic i_rx_rate_mismatch,
  input wire logic i_tx_valid,
  input wire psc_pkg::psc_port_t i_tx_port,
  input wire psc_pkg::psc_len_t i_tx_len,
  input wire logic i_tx_unicast,
  input wire logic i_tx_pause,
  input wire logic i_tx_underrun,
  input wire logic i_tx_late_col,
  input wire logic [4:0] i_tx_col_count,
  input wire logic i_col_valid,
  input wire psc_pkg::psc_port_t i_col_port,
  input wire psc_pkg::psc_len_t i_col_offset,
  input wire logic i_bm_delay_discard,
  input wire psc_pkg::psc_port_t i_bm_port,
  input wire logic i_qm_filter,
  input wire psc_pkg::psc_port_t i_qm_port,
  input wire psc_pkg::psc_len_t i_size_cap,
  input wire logic [9:0] i_size_cap_en,
  input wire logic i_rd_req,
  input wire psc_pkg::psc_port_t i_rd_port,
  input wire logic [4:0] i_rd_addr,
  output logic o_rd_valid,
  output psc_pkg::psc_word_t o_rd_data,
  output logic o_wrap_valid,
  output logic [63:0] o_wrap_word
);
  import psc_pkg::*;
  typedef struct packed {
    psc_hit_t hit;
    psc_port_t rx_port;
    psc_port_t tx_port;
    psc_port_t col_port;
    psc_port_t bm_port;
    psc_port_t qm_port;
    psc_len_t rx_len;
    psc_len_t tx_len;
    logic [`PSC_NUM_PORTS-1:0][31:0] good_octet_count;
    logic [`PSC_NUM_PORTS-1:0][31:0] good_frame_count;
    logic [`PSC_NUM_PORTS-1:0][31:0] very_long_event_count;
    logic [`PSC_NUM_PORTS-1:0][31:0] error_total;
    logic rd_valid;
    psc_word_t rd_data;
  } psc_top_s;
  psc_top_s q;
  psc_top_s d;
  psc_ev_if ev ();

  always_comb
  begin
    psc_len_t lim;
    logic nocol;
    logic sized;
    logic toolong;
    logic good;
    logic fail;
    logic [2:0] nerr;
    lim = '0;
    nocol = 1'b0;
    sized = 1'b0;
    toolong = 1'b0;
    good = 1'b0;
    fail = 1'b0;
    nerr = '0;
    d = q;
    d.hit = '0;
    d.rx_port = i_rx_port;
    d.tx_port = i_tx_port;
    d.col_port = i_col_port;
    d.bm_port = i_bm_port;
    d.qm_port = i_qm_port;
    d.rx_len = i_rx_len;
    d.tx_len = i_tx_len;
    // The cap only applies while that port's enable is set.
    if (i_rx_port < `PSC_NUM_PORTS && i_size_cap_en[i_rx_port])
      lim = i_size_cap;
    else
      lim = i_rx_tagged ? `PSC_MAX_TAGGED : `PSC_MAX_UNTAGGED;
    nocol = !i_rx_collision;
    sized = i_rx_len >= `PSC_MIN_FRAME && i_rx_len <= lim;
    toolong = i_rx_len > lim;
    good = sized && !i_rx_fcs_err && nocol;
    if (i_rx_valid)
    begin
      // Receive side, MAC qualified.
      d.hit[5] = nocol;
      d.hit[6] = nocol;
      d.hit[7] = 1'b1;
      d.hit[8] = 1'b1;
      d.hit[9] = i_rx_pause && nocol;
      d.hit[10] = i_rx_mcast && good;
      d.hit[11] = i_rx_bcast && good;
      // Size bins count good and bad frames.
      d.hit[12] = i_rx_len == `PSC_MIN_FRAME && nocol;
      d.hit[13] = toolong && i_rx_fcs_err && nocol;
      d.hit[14] = i_rx_len > `PSC_MIN_FRAME && i_rx_len <= `PSC_BIN_127
        && nocol;
      d.hit[15] = toolong && nocol;
      d.hit[16] = i_rx_len > `PSC_BIN_127 && i_rx_len <= `PSC_BIN_255
        && nocol;
      d.hit[17] = i_rx_len > `PSC_BIN_255 && i_rx_len <= `PSC_BIN_511
        && nocol;
      d.hit[18] = i_rx_len > `PSC_BIN_511 && i_rx_len <= `PSC_BIN_1023
        && nocol;
      d.hit[19] = i_rx_len > `PSC_BIN_1023 && i_rx_len <= lim && nocol;
      // Error words.
      d.hit[20] = i_rx_len < `PSC_MIN_FRAME && i_rx_fcs_err && nocol;
      d.hit[21] = sized && i_rx_misaligned && !i_rx_frame_err
        && nocol;
      d.hit[22] = i_rx_len >= `PSC_SHORT_EVENT
        && i_rx_len < `PSC_MIN_FRAME && nocol;
      d.hit[23] = sized && i_rx_fcs_err && !i_rx_frame_err
        && nocol;
      d.hit[24] = i_rx_len < `PSC_SHORT_EVENT && nocol;
      d.hit[26] = i_rx_drop;
      d.hit[`PSC_HIT_GOOD] = good;
      d.hit[`PSC_HIT_VLONG] = i_rx_jabber_lockup_timer;
      d.hit[`PSC_HIT_MISMATCH] = i_rx_rate_mismatch;
    end
    if (i_tx_valid)
    begin
      fail = i_tx_underrun || i_tx_late_col
        || i_tx_col_count == `PSC_COL_LIMIT;
      d.hit[0] = 1'b1;
      d.hit[1] = i_tx_unicast && !fail;
      d.hit[2] = fail;
      d.hit[3] = i_tx_pause;
      d.hit[4] = !i_tx_unicast;
    end
    if (i_col_valid)
    begin
      d.hit[25] = 1'b1;
      d.hit[29] = i_col_offset > `PSC_LATE_COL_THRESHOLD;
    end
    // Two counts come from outside the MAC.
    d.hit[27] = i_qm_filter;
    d.hit[28] = i_bm_delay_discard;
    // Extra per-port counters kept beside the packed memory.
    for (int p = 0; p < `PSC_NUM_PORTS; p++)
    begin
      nerr = '0;
      if (q.rx_port == 4'(p))
      begin
        if (q.hit[`PSC_HIT_GOOD])
        begin
          d.good_octet_count[p] = q.good_octet_count[p]
            + {18'h0, q.rx_len};
          d.good_frame_count[p] = q.good_frame_count[p] + 32'h1;
        end
        if (q.hit[`PSC_HIT_VLONG])
          d.very_long_event_count[p] = q.very_long_event_count[p]
            + 32'h1;
        nerr = 3'(q.hit[23]) + 3'(q.hit[21]) + 3'(q.hit[15])
          + 3'(q.hit[24]) + 3'(q.hit[`PSC_HIT_VLONG])
          + 3'(q.hit[`PSC_HIT_MISMATCH]);
      end
      if (q.col_port == 4'(p) && q.hit[29])
        nerr = nerr + 3'h1;
      d.error_total[p] = q.error_total[p] + {29'h0, nerr};
    end
    // Host read: words 0 to F from the bank, 10 to 13 from here.
    d.rd_valid = i_rd_req;
    if (i_rd_req)
    begin
      if (i_rd_port >= `PSC_NUM_PORTS)
        d.rd_data = `PSC_RESET_COUNT;
      else
        case (i_rd_addr)
          `PSC_ADDR_GOOD_OCTET: d.rd_data = q.good_octet_count[i_rd_port];
          `PSC_ADDR_GOOD_FRAME: d.rd_data = q.good_frame_count[i_rd_port];
          `PSC_ADDR_VLONG: d.rd_data = q.very_long_event_count[i_rd_port];
          `PSC_ADDR_ERR_TOTAL: d.rd_data = q.error_total[i_rd_port];
          default: d.rd_data = i_rd_addr[4] ? `PSC_RESET_COUNT : ev.rd_data;
        endcase
    end
  end

  assign ev.hit = q.hit;
  assign ev.rx_port = q.rx_port;
  assign ev.tx_port = q.tx_port;
  assign ev.col_port = q.col_port;
  assign ev.bm_port = q.bm_port;
  assign ev.qm_port = q.qm_port;
  assign ev.rx_len = q.rx_len;
  assign ev.tx_len = q.tx_len;
  assign ev.rd_port = i_rd_port;
  assign ev.rd_word = i_rd_addr[3:0];
  assign o_rd_valid = q.rd_valid;
  assign o_rd_data = q.rd_data;

  psc_counter_bank u_bank
  (
    .i_ref_clk(i_ref_clk),
    .i_reset(i_reset),
    .i_clk_en(i_clk_en),
    .ev(ev)
  );

  psc_wrap_report u_rpt
  (
    .i_ref_clk(i_ref_clk),
    .i_reset(i_reset),
    .i_clk_en(i_clk_en),
    .ev(ev),
    .o_wrap_valid(o_wrap_valid),
    .o_wrap_word(o_wrap_word)
  );

  always_ff @(posedge i_ref_clk or posedge i_reset)
  begin
    if (i_reset)
      q <= '0;
    else if (i_clk_en)
      q <= d;
  end
endmodule

/* verif/psc_stats_monitor.sv */
// Purpose: Timing checks on the read and wrap report ports.
// Assumes: Bound into the top; a single clock domain.
// Notes: Report latency is bounded by a quiet-cycle counter.
`timescale 1ns/10ps
module psc_stats_monitor
(
  input wire logic i_ref_clk,
  input wire logic i_reset,
  input wire logic i_clk_en,
  input wire logic i_rx_valid,
  input wire logic i_tx_valid,
  input wire logic i_col_valid,
  input wire logic i_bm_delay_discard,
  input wire logic i_qm_filter,
  input wire logic i_rd_req,
  input wire psc_pkg::psc_port_t i_rd_port,
  input wire logic [4:0] i_rd_addr,
  input wire logic o_rd_valid,
  input wire psc_pkg::psc_word_t o_rd_data,
  input wire logic o_wrap_valid,
  input wire logic [63:0] o_wrap_word
);
  logic [4:0] quiet_q;
  logic [4:0] quiet_d;
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (i_reset);
  // Saturating, so a stray report long after traffic still fails.
  always_comb
  begin
    quiet_d = quiet_q;
    if (i_rx_valid || i_tx_valid || i_col_valid || i_bm_delay_discard
      || i_qm_filter)
      quiet_d = 5'h00;
    else if (i_clk_en && quiet_q != 5'h1F)
      quiet_d = quiet_q + 5'h01;
  end
  always_ff @(posedge i_ref_clk or posedge i_reset)
  begin
    if (i_reset)
      quiet_q <= 5'h1F;
    else
      quiet_q <= quiet_d;
  end
  sequence s_rd_taken;
    i_rd_req && i_clk_en;
  endsequence
  sequence s_rd_refused;
    s_rd_taken ##0 (i_rd_port > 4'h9 || i_rd_addr > 5'h13);
  endsequence
  property p_rd_ans;
    s_rd_taken |=> o_rd_valid;
  endproperty
  property p_rd_none;
    (!i_rd_req && i_clk_en) |=> !o_rd_valid;
  endproperty
  property p_rd_refused;
    s_rd_refused |=> o_rd_valid && o_rd_data == 32'h0;
  endproperty
  property p_rd_hold;
    !o_rd_valid |-> $stable(o_rd_data);
  endproperty
  property p_wrap_hold;
    !o_wrap_valid |-> $stable(o_wrap_word);
  endproperty
  property p_wrap_top;
    o_wrap_valid |-> o_wrap_word[63:34] == 30'h0 && o_wrap_word[33:30] < 4'hA;
  endproperty
  property p_wrap_flags;
    o_wrap_valid |-> o_wrap_word[29:0] != 30'h0;
  endproperty
  property p_wrap_cause;
    o_wrap_valid |-> quiet_q < 5'h18;
  endproperty
  a_rd_ans: assert property (p_rd_ans)
    else $error("read not answered");
  a_rd_none: assert property (p_rd_none)
    else $error("read answer without request");
  a_rd_refused: assert property (p_rd_refused)
    else $error("refused read not zero");
  a_rd_hold: assert property (p_rd_hold)
    else $error("read data changed between reads");
  a_wrap_hold: assert property (p_wrap_hold)
    else $error("wrap word changed between reports");
  a_wrap_top: assert property (p_wrap_top)
    else $error("wrap word status bits wrong");
  a_wrap_flags: assert property (p_wrap_flags)
    else $error("wrap report with no flag");
  a_wrap_cause: assert property (p_wrap_cause)
    else $error("wrap report without recent event");
endmodule

/* verif/psc_host_model.sv */
// Purpose: Host that reads counter words one at a time.
// Assumes: A read is taken at the edge after the request is set.
// Notes: Idle address lines show the inverse of the last access.
`timescale 1ns/10ps
module psc_host_model
(
  input wire logic i_ref_clk,
  input wire logic i_rd_valid,
  input wire psc_pkg::psc_word_t i_rd_data,
  output logic o_rd_req,
  output psc_pkg::psc_port_t o_rd_port,
  output logic [4:0] o_rd_addr
);
  import psc_pkg::*;
  initial
  begin
    o_rd_req = 1'b0;
    o_rd_port = 4'hF;
    o_rd_addr = 5'h1F;
  end
  // A slow host waits gap plus one cycles before it asks.
  task automatic read(input psc_port_t p, input logic [4:0] a,
    input int gap, output psc_word_t d);
    repeat (gap) @(negedge i_ref_clk);
    @(negedge i_ref_clk);
    o_rd_req = 1'b1;
    o_rd_port = p;
    o_rd_addr = a;
    @(negedge i_ref_clk);
    o_rd_req = 1'b0;
    o_rd_port = ~p;
    o_rd_addr = ~a;
    d = (i_rd_valid === 1'b1) ? i_rd_data : 32'hXXXXXXXX;
  endtask
endmodule

/* verif/psc_stats_top_tb.sv */
// Purpose: Self-checking bench for the port statistics block.
// Assumes: Inputs change at the falling edge of a 40 MHz clock.
// Notes: Each scenario but the reset one uses its own port so counts start at zero.
`timescale 1ns/10ps
module psc_stats_top_tb;
  import psc_pkg::*;
  localparam logic [4:0] RX = 5'h01;
  localparam logic [4:0] TX = 5'h02;
  localparam logic [4:0] COL = 5'h04;
  localparam logic [4:0] BM = 5'h08;
  localparam logic [4:0] QM = 5'h10;
  logic i_ref_clk = 1'b0;
  logic i_reset = 1'b1;
  logic i_clk_en = 1'b1;
  logic [4:0] src = 5'h00;
  logic [15:0] fl = 16'h0000;
  psc_port_t pt = 4'h0;
  psc_len_t ln = 14'h0000;
  psc_len_t i_size_cap = 14'h0000;
  logic [9:0] i_size_cap_en = 10'h000;
  logic i_rd_req;
  psc_port_t i_rd_port;
  logic [4:0] i_rd_addr;
  logic o_rd_valid;
  psc_word_t o_rd_data;
  logic o_wrap_valid;
  logic [63:0] o_wrap_word;
  int miscompares = 0;
  int checks_done = 0;

  always #12.5 i_ref_clk = ~i_ref_clk;

  psc_stats_top DUT (.i_ref_clk, .i_reset, .i_clk_en,
    .i_rx_valid(src[0]), .i_rx_port(pt), .i_rx_len(ln),
    .i_rx_tagged(fl[10]), .i_rx_fcs_err(fl[0]), .i_rx_frame_err(fl[1]),
    .i_rx_misaligned(fl[2]), .i_rx_collision(fl[3]), .i_rx_pause(fl[4]),
    .i_rx_mcast(fl[5]), .i_rx_bcast(fl[6]), .i_rx_drop(fl[7]),
    .i_rx_jabber_lockup_timer(fl[8]), .i_rx_rate_mismatch(fl[9]),
    .i_tx_valid(src[1]), .i_tx_port(pt), .i_tx_len(ln),
    .i_tx_unicast(fl[0]), .i_tx_pause(fl[1]), .i_tx_underrun(fl[2]),
    .i_tx_late_col(fl[3]), .i_tx_col_count(fl[15:11]),
    .i_col_valid(src[2]), .i_col_port(pt), .i_col_offset(ln),
    .i_bm_delay_discard(src[3]), .i_bm_port(pt), .i_qm_filter(src[4]),
    .i_qm_port(pt), .i_size_cap, .i_size_cap_en, .i_rd_req, .i_rd_port,
    .i_rd_addr, .o_rd_valid, .o_rd_data, .o_wrap_valid, .o_wrap_word);

  psc_host_model host (.i_ref_clk, .i_rd_valid(o_rd_valid),
    .i_rd_data(o_rd_data), .o_rd_req(i_rd_req), .o_rd_port(i_rd_port),
    .o_rd_addr(i_rd_addr));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED t=%0t seen %h want %h", $time, seen, exp);
    end
  endtask

  // Consecutive calls give back-to-back events on the same strobe.
  task automatic ev(input logic [4:0] s, input psc_port_t p,
    input psc_len_t l, input logic [15:0] f);
    @(negedge i_ref_clk);
    src = s;
    pt = p;
    ln = l;
    fl = f;
  endtask

  task automatic idle;
    @(negedge i_ref_clk);
    src = 5'h00;
    ln = ~ln;
    fl = ~fl;
  endtask

  task automatic rd(input psc_port_t p, input logic [4:0] a,
    input logic [4:0] sh, input logic [5:0] wd, input logic [15:0] e);
    psc_word_t w;
    host.read(p, a, 2, w);
    w = w >> sh;
    chk(w & ((32'h1 << wd) - 32'h1), {16'h0000, e});
  endtask

  task automatic t_sizes;
    ev(RX, 4'h0, 14'h0040, 16'h0000);
    ev(RX, 4'h0, 14'h05F2, 16'h0400);
    ev(RX, 4'h0, 14'h05EF, 16'h0000);
    ev(RX, 4'h0, 14'h05EE, 16'h0000);
    ev(RX, 4'h0, 14'h05F3, 16'h0400);
    ev(RX, 4'h0, 14'h0064, 16'h0008);
    idle;
    rd(4'h0, 5'h10, 5'h00, 6'h20, 16'h0C20);
    rd(4'h0, 5'h11, 5'h00, 6'h20, 16'h0003);
    rd(4'h0, 5'h08, 5'h00, 6'h18, 16'h0001);
    rd(4'h0, 5'h09, 5'h18, 6'h08, 16'h0002);
    rd(4'h0, 5'h0B, 5'h10, 6'h10, 16'h0002);
    $display("done sizes");
  endtask

  task automatic t_short;
    ev(RX, 4'h1, 14'h0009, 16'h0001);
    ev(RX, 4'h1, 14'h0009, 16'h0008);
    ev(RX, 4'h1, 14'h000A, 16'h0001);
    ev(RX, 4'h1, 14'h003F, 16'h0000);
    ev(RX, 4'h1, 14'h0064, 16'h0001);
    ev(RX, 4'h1, 14'h0064, 16'h0003);
    ev(RX, 4'h1, 14'h0064, 16'h0004);
    ev(RX, 4'h1, 14'h0064, 16'h0006);
    idle;
    rd(4'h1, 5'h0D, 5'h10, 6'h10, 16'h0001);
    rd(4'h1, 5'h0C, 5'h18, 6'h08, 16'h0002);
    rd(4'h1, 5'h0D, 5'h00, 6'h10, 16'h0001);
    rd(4'h1, 5'h0C, 5'h10, 6'h08, 16'h0001);
    rd(4'h1, 5'h13, 5'h00, 6'h20, 16'h0003);
    $display("done short and error frames");
  endtask

  task automatic t_col;
    ev(COL, 4'h2, 14'h0040, 16'h0000);
    ev(COL, 4'h2, 14'h0041, 16'h0000);
    ev(RX, 4'h2, 14'h07D0, 16'h0100);
    ev(RX, 4'h2, 14'h0064, 16'h0200);
    idle;
    rd(4'h2, 5'h0E, 5'h00, 6'h10, 16'h0002);
    rd(4'h2, 5'h0F, 5'h18, 6'h08, 16'h0001);
    rd(4'h2, 5'h12, 5'h00, 6'h20, 16'h0001);
    rd(4'h2, 5'h13, 5'h00, 6'h20, 16'h0004);
    $display("done collisions");
  endtask

  task automatic t_tx;
    ev(TX, 4'h3, 14'h0064, 16'h0001);
    idle;
    rd(4'h3, 5'h00, 5'h00, 6'h20, 16'h0064);
    rd(4'h3, 5'h01, 5'h00, 6'h18, 16'h0001);
    ev(TX, 4'h3, 14'h0040, 16'h0004);
    ev(TX, 4'h3, 14'h0040, 16'h0008);
    ev(TX, 4'h3, 14'h0040, 16'h8000);
    ev(TX, 4'h3, 14'h0040, 16'h7800);
    ev(TX, 4'h3, 14'h0040, 16'h0002);
    idle;
    rd(4'h3, 5'h01, 5'h18, 6'h08, 16'h0003);
    rd(4'h3, 5'h02, 5'h00, 6'h10, 16'h0001);
    $display("done transmit");
  endtask

  task automatic t_mgr;
    ev(BM | QM, 4'h4, 14'h0000, 16'h0000);
    ev(BM, 4'h4, 14'h0000, 16'h0000);
    idle;
    rd(4'h4, 5'h0F, 5'h00, 6'h10, 16'h0001);
    rd(4'h4, 5'h0F, 5'h10, 6'h08, 16'h0002);
    $display("done manager events");
  endtask

  task automatic t_cap;
    @(negedge i_ref_clk);
    i_size_cap = 14'h0064;
    i_size_cap_en = 10'h020;
    ev(RX, 4'h5, 14'h0064, 16'h0000);
    ev(RX, 4'h5, 14'h0065, 16'h0000);
    ev(RX, 4'h6, 14'h0065, 16'h0000);
    idle;
    rd(4'h5, 5'h11, 5'h00, 6'h20, 16'h0001);
    rd(4'h5, 5'h09, 5'h18, 6'h08, 16'h0001);
    rd(4'h6, 5'h11, 5'h00, 6'h20, 16'h0001);
    $display("done size cap");
  endtask

  task automatic t_wrap;
    int n;
    for (n = 0; n < 256; n++)
      ev(RX, 4'h7, 14'h0040, 16'h0010);
    idle;
    for (n = 0; n < 30 && o_wrap_valid !== 1'b1; n++)
      @(negedge i_ref_clk);
    chk(o_wrap_word[63:32], 32'h00000001);
    chk(o_wrap_word[31:0], 32'hC0000200);
    rd(4'h7, 5'h06, 5'h18, 6'h08, 16'h0000);
    rd(4'h7, 5'h06, 5'h00, 6'h18, 16'h0100);
    $display("done wrap");
  endtask

  task automatic t_refuse;
    ev(RX, 4'hA, 14'h0040, 16'h0000);
    ev(RX, 4'h9, 14'h0040, 16'h0000);
    idle;
    rd(4'h9, 5'h11, 5'h00, 6'h20, 16'h0001);
    rd(4'hA, 5'h11, 5'h00, 6'h20, 16'h0000);
    rd(4'h0, 5'h14, 5'h00, 6'h20, 16'h0000);
    $display("done refused reads");
  endtask

  // An event offered while the enable is low must leave no trace.
  task automatic t_freeze;
    @(negedge i_ref_clk);
    i_clk_en = 1'b0;
    ev(RX, 4'h8, 14'h0040, 16'h0000);
    idle;
    @(negedge i_ref_clk);
    i_clk_en = 1'b1;
    rd(4'h8, 5'h11, 5'h00, 6'h20, 16'h0000);
    $display("done clock enable");
  endtask

  // A reset in mid-run clears counts and the held wrap word.
  task automatic t_reset;
    @(negedge i_ref_clk);
    i_reset = 1'b1;
    @(negedge i_ref_clk);
    i_reset = 1'b0;
    chk(o_wrap_word[31:0], 32'h00000000);
    rd(4'h0, 5'h11, 5'h00, 6'h20, 16'h0000);
    rd(4'h7, 5'h06, 5'h00, 6'h18, 16'h0000);
    $display("done mid-run reset");
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial
  begin
    repeat (20) @(posedge i_ref_clk);
    @(negedge i_ref_clk);
    i_reset = 1'b0;
    t_sizes;
    t_short;
    t_col;
    t_tx;
    t_mgr;
    t_cap;
    t_wrap;
    t_refuse;
    t_freeze;
    t_reset;
    report_and_stop;
  end

  // The tests need well under a thousand cycles; this is eight thousand.
  initial
  begin
    #200000;
    miscompares++;
    report_and_stop;
  end
endmodule

bind psc_stats_top psc_stats_monitor mon (.i_ref_clk, .i_reset, .i_clk_en,
  .i_rx_valid, .i_tx_valid, .i_col_valid, .i_bm_delay_discard, .i_qm_filter,
  .i_rd_req, .i_rd_port, .i_rd_addr, .o_rd_valid, .o_rd_data, .o_wrap_valid,
  .o_wrap_word);
